// *** src/sfb_pkg.sv ***
package sfb_pkg;
	localparam int SYNC_STAGES = 2;
	localparam int BYTE_BITS   = 8;
	localparam int FIFO_WIDTH  = 8;
	localparam int FIFO_DEPTH  = 32;
	localparam logic [2:0] BIT_FIRST = 3'h7;
	localparam logic [2:0] BIT_LAST  = 3'h0;
	localparam logic [1:0] GUARD_RESET = 2'h0;

	typedef enum logic {
		SFB_STANDBY,
		SFB_ACTIVE
	} sfb_power_t;

	typedef struct packed {
		logic sel_n;
		logic sclk;
		logic sdi;
		logic pause_n;
		logic guard_n;
	} sfb_pins_t;

	// idle pin levels, so leaving reset shows no false clock edge while the clock idles low
	localparam sfb_pins_t PINS_IDLE = '{sel_n: 1'b1, sclk: 1'b0, sdi: 1'b0,
	                                    pause_n: 1'b1, guard_n: 1'b1};

	typedef struct packed {
		logic [7:0] data;
		logic       first;
	} sfb_rx_t;
endpackage

// *** src/sfb_fifo.sv ***
`timescale 1ns/100ps
`default_nettype none
module sfb_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32
) (
	input  wire logic             clk_i,
	input  wire logic             reset_i,
	input  wire logic             flush_i,
	input  wire logic [WIDTH-1:0] wr_data_i,
	input  wire logic             wr_valid_i,
	output logic                  wr_ready_o,
	output logic      [WIDTH-1:0] rd_data_o,
	output logic                  rd_valid_o,
	input  wire logic             rd_ready_i
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	assign wr_ready_o = (cnt_r != (AW+1)'(DEPTH));
	assign rd_valid_o = (cnt_r != '0);
	assign push       = wr_valid_i && wr_ready_o;
	assign pop        = rd_valid_o && rd_ready_i;
	assign rd_data_o  = mem_r[rp_r];

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem_r[wp_r] <= wr_data_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i || flush_i) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= (wp_r == AW'(DEPTH-1)) ? '0 : wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= (rp_r == AW'(DEPTH-1)) ? '0 : rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// *** src/sfb_bus_if.sv ***
`timescale 1ns/100ps
`default_nettype none
module sfb_bus_if (
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       sel_n_i,
	input  wire logic       sclk_i,
	input  wire logic       serial_in_line_i,
	input  wire logic       pause_n_i,
	input  wire logic       guard_n_i,
	output logic            serial_out_line_o,
	output logic            serial_out_line_oe_o,
	input  wire logic       busy_i,
	output logic            active_o,
	output logic            armed_o,
	output logic            paused_o,
	output logic [7:0]      rx_data_o,
	output logic            rx_first_o,
	output logic            rx_valid_o,
	input  wire logic       rx_ready_i,
	output logic            rx_overrun_o,
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_valid_i,
	output logic            tx_ready_o,
	input  wire logic [1:0] guard_bits_i,
	input  wire logic       guard_wr_i,
	output logic [1:0]      region_guard_bits_o
);
	sfb_pkg::sfb_pins_t s1_r;
	sfb_pkg::sfb_pins_t s2_r;
	sfb_pkg::sfb_pins_t prev_r;
	sfb_pkg::sfb_rx_t   rx_word;
	sfb_pkg::sfb_power_t power_r;
	logic [2:0] bit_r;
	logic [6:0] shin_r;
	logic [7:0] shout_r;
	logic       first_r;
	logic       paused_r;
	logic       armed_r;
	logic       dead_r;
	logic       out_r;
	logic       rise;
	logic       fall;
	logic       sel_fall;
	logic       sel_rise;
	logic       live;
	logic       byte_done;
	logic       fifo_wr_ready;
	logic [8:0] fifo_out;

	// two-stage sync, only s2 is read
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			s1_r   <= sfb_pkg::PINS_IDLE;
			s2_r   <= sfb_pkg::PINS_IDLE;
			prev_r <= sfb_pkg::PINS_IDLE;
		end else begin
			s1_r   <= '{sel_n: sel_n_i, sclk: sclk_i, sdi: serial_in_line_i,
			            pause_n: pause_n_i, guard_n: guard_n_i};
			s2_r   <= s1_r;
			prev_r <= s2_r;
		end
	end

	// same edges whatever the idle level of the clock
	assign rise     = s2_r.sclk && !prev_r.sclk;
	assign fall     = !s2_r.sclk && prev_r.sclk;
	assign sel_fall = !s2_r.sel_n && prev_r.sel_n;
	assign sel_rise = s2_r.sel_n && !prev_r.sel_n;
	assign live     = !s2_r.sel_n && armed_r && !paused_r && !dead_r;

	// nothing is decoded until the first select edge
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			armed_r <= 1'b0;
		end else if (sel_fall) begin
			armed_r <= 1'b1;
		end
	end

	// pause only while selected; changes when clock is low
	always_ff @(posedge clk_i) begin
		if (reset_i || s2_r.sel_n) begin
			paused_r <= 1'b0;
		end else if (!s2_r.sclk) begin
			paused_r <= !s2_r.pause_n;
		end
	end

	// deselect in pause kills the link until pause released before reselect
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			dead_r <= 1'b0;
		end else if (sel_rise && paused_r) begin
			dead_r <= 1'b1;
		end else if (s2_r.pause_n && s2_r.sel_n) begin
			dead_r <= 1'b0;
		end
	end

	assign byte_done = live && rise && (bit_r == sfb_pkg::BIT_LAST);

	// msb-first receive on rising edge
	always_ff @(posedge clk_i) begin
		if (reset_i || sel_fall || s2_r.sel_n) begin
			bit_r   <= sfb_pkg::BIT_FIRST;
			shin_r  <= '0;
			first_r <= 1'b1;
		end else if (live && rise) begin
			shin_r <= {shin_r[5:0], s2_r.sdi};
			bit_r  <= bit_r - 3'h1;
			if (byte_done) begin
				first_r <= 1'b0;
			end
		end
	end

	// overrun sticky per frame; buffer full means a lost byte
	always_ff @(posedge clk_i) begin
		if (reset_i || sel_fall) begin
			rx_overrun_o <= 1'b0;
		end else if (byte_done && !fifo_wr_ready) begin
			rx_overrun_o <= 1'b1;
		end
	end

	assign rx_word = '{data: {shin_r, s2_r.sdi}, first: first_r};

	sfb_fifo #(
		.WIDTH(sfb_pkg::FIFO_WIDTH + 1),
		.DEPTH(sfb_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_i     (clk_i),
		.reset_i   (reset_i),
		.flush_i   (1'b0),
		.wr_data_i (rx_word),
		.wr_valid_i(byte_done),
		.wr_ready_o(fifo_wr_ready),
		.rd_data_o (fifo_out),
		.rd_valid_o(rx_valid_o),
		.rd_ready_i(rx_ready_i)
	);
	assign rx_data_o  = fifo_out[8:1];
	assign rx_first_o = fifo_out[0];

	// tx byte loaded at start of each byte but the first when the clock idles low; shifted on falling edge
	assign tx_ready_o = live && fall && (bit_r == sfb_pkg::BIT_FIRST);
	always_ff @(posedge clk_i) begin
		if (reset_i || sel_fall) begin
			shout_r <= '1;
			out_r   <= 1'b1;
		end else if (live && fall) begin
			if (bit_r == sfb_pkg::BIT_FIRST) begin
				out_r   <= tx_valid_i ? tx_data_i[7] : 1'b1;
				shout_r <= tx_valid_i ? {tx_data_i[6:0], 1'b1} : '1;
			end else begin
				out_r   <= shout_r[7];
				shout_r <= {shout_r[6:0], 1'b1};
			end
		end
	end
	assign serial_out_line_o = out_r;
	// only a selected, unpaused device drives
	assign serial_out_line_oe_o = !s2_r.sel_n && !paused_r && !dead_r;

	// standby waits for internal cycles to finish
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			power_r <= sfb_pkg::SFB_STANDBY;
		end else if (!s2_r.sel_n) begin
			power_r <= sfb_pkg::SFB_ACTIVE;
		end else if (!busy_i) begin
			power_r <= sfb_pkg::SFB_STANDBY;
		end
	end
	assign active_o = (power_r == sfb_pkg::SFB_ACTIVE);
	assign armed_o  = armed_r;
	assign paused_o = paused_r;

	// guard bits frozen while write guard held low
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			region_guard_bits_o <= sfb_pkg::GUARD_RESET;
		end else if (guard_wr_i && s2_r.guard_n) begin
			region_guard_bits_o <= guard_bits_i;
		end
	end
endmodule
`default_nettype wire

// *** verification/sfb_bus_if_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module sfb_bus_if_chk (
	input wire logic       clk_i,
	input wire logic       reset_i,
	input wire logic       sel_n_i,
	input wire logic       guard_n_i,
	input wire logic       busy_i,
	input wire logic       serial_out_line_oe_o,
	input wire logic       active_o,
	input wire logic       armed_o,
	input wire logic       paused_o,
	input wire logic       rx_valid_o,
	input wire logic       rx_overrun_o,
	input wire logic       tx_ready_o,
	input wire logic [1:0] region_guard_bits_o
);
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (reset_i);
	// pin windows cover the synchroniser plus edge detect
	chk_desel_hiz: assert property (sel_n_i [*5] |-> !serial_out_line_oe_o)
		else $error("deselected output driven");
	chk_pause_hiz: assert property (paused_o |-> !serial_out_line_oe_o)
		else $error("paused output driven");
	chk_sel_active: assert property (!sel_n_i [*5] |-> active_o)
		else $error("selected but not active");
	chk_idle_standby: assert property ((sel_n_i && !busy_i) [*6] |-> !active_o)
		else $error("idle but not standby");
	chk_busy_active: assert property (sel_n_i && busy_i && active_o |=> active_o)
		else $error("standby while busy");
	chk_desel_nopause: assert property (sel_n_i [*5] |-> !$rose(paused_o))
		else $error("pause entered deselected");
	chk_arm_first: assert property (!armed_o |-> !rx_valid_o)
		else $error("byte before first select");
	chk_guard_freeze: assert property (!guard_n_i [*5] |=> $stable(region_guard_bits_o))
		else $error("guard bits changed");
	chk_ready_pulse: assert property (tx_ready_o |=> !tx_ready_o)
		else $error("tx ready held two cycles");
	cover property ($rose(paused_o));
	cover property (rx_overrun_o);
	cover property (rx_valid_o && armed_o);
endmodule
bind sfb_bus_if sfb_bus_if_chk u_sfb_bus_if_chk (.*);
`default_nettype wire

// *** verification/sfb_master.sv ***
`timescale 1ns/100ps
`default_nettype none
module sfb_master (
	output logic      sel_n_o,
	output logic      sclk_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	logic cpol = 1'b0; // idle level
	initial begin
		sel_n_o = 1'b1;
		sclk_o = 1'b0;
		sdi_o = 1'b0;
	end
	// idle level set only while deselected
	task automatic mode(input logic p);
		cpol = p;
		sclk_o = p;
	endtask
	// never moves with the clock
	task automatic sel(input logic lvl);
		#43 sel_n_o = lvl;
		if (lvl)
			sdi_o = ~sdi_o;
		#40;
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			sclk_o = 1'b0;
			sdi_o = tx[i];
			#40 sclk_o = 1'b1;
			// sample late in the high phase, after the synchroniser delay
			#40 rx[i] = sdo_i;
		end
		sclk_o = cpol;
	endtask
endmodule
`default_nettype wire

// *** verification/serial_flash_bus_interface_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module serial_flash_bus_interface_tb;
	logic clk_i, sel_n_i, sclk_i, serial_in_line_i;
	logic reset_i = 1'b1, pause_n_i = 1'b1, guard_n_i = 1'b0, busy_i = 1'b0;
	logic rx_ready_i = 1'b1, tx_valid_i = 1'b1, guard_wr_i = 1'b0, last_out = 1'b1;
	logic [7:0] tx_data_i = 8'h00, rx_data_o;
	logic [1:0] guard_bits_i = 2'h3, region_guard_bits_o;
	logic serial_out_line_o, serial_out_line_oe_o, active_o, armed_o, paused_o;
	logic rx_first_o, rx_valid_o, rx_overrun_o, tx_ready_o;
	logic [16:0] lfsr = 17'h13730;
	function automatic logic [16:0] lfsr_next(input logic [16:0] v);
		return {v[15:0], v[16] ^ v[13]};
	endfunction
	int errors, n_compared, cyc;
	sfb_pkg::sfb_rx_t q[$];
	wire sdo = serial_out_line_oe_o ? serial_out_line_o : ~last_out;
	sfb_bus_if u_sfb_bus_if (.*);
	sfb_master u_sfb_master (.sel_n_o(sel_n_i), .sclk_o(sclk_i), .sdi_o(serial_in_line_i),
		.sdo_i(sdo));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	task automatic tally_and_finish;
		if (errors == 0 && n_compared > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input logic [8:0] seen, input logic [8:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	always @(posedge clk_i) begin
		cyc++;
		if (serial_out_line_oe_o)
			last_out <= serial_out_line_o;
		if (rx_valid_o && rx_ready_i)
			check({rx_data_o, rx_first_o}, q.pop_front());
		if (cyc == 20000) begin
			errors++;
			tally_and_finish;
		end
	end
	// keep: bytes the fifo still has room for; pz pauses after the first byte
	task automatic frame(input int n, input int keep, input bit pz);
		logic [7:0] t, r;
		lfsr = lfsr_next(lfsr);
		t = lfsr[15:8];
		@(posedge clk_i) tx_data_i <= t;
		u_sfb_master.sel(1'b0);
		for (int i = 0; i < n; i++) begin
			lfsr = lfsr_next(lfsr);
			if (i < keep)
				q.push_back({lfsr[7:0], i == 0});
			u_sfb_master.xfer(lfsr[7:0], r);
			if (i > 0)
				check({r, 1'b0}, {t, 1'b0});
			if (pz && i == 0) begin
				@(posedge clk_i) pause_n_i <= 1'b0;
				repeat (6) @(posedge clk_i);
				check({7'h00, paused_o, serial_out_line_oe_o}, 9'h002);
				u_sfb_master.xfer(8'h5a, r);
				@(posedge clk_i) pause_n_i <= 1'b1;
				repeat (6) @(posedge clk_i);
			end
		end
		u_sfb_master.sel(1'b1);
	endtask
	initial begin
		logic [7:0] r;
		repeat (5) @(posedge clk_i);
		reset_i <= 1'b0;
		repeat (4) @(posedge clk_i);
		u_sfb_master.xfer(8'ha5, r);
		check({8'h00, armed_o}, 9'h000);
		frame(2, 2, 1'b0);
		check({8'h00, armed_o}, 9'h001);
		u_sfb_master.mode(1'b1);
		frame(3, 3, 1'b0);
		u_sfb_master.mode(1'b0);
		frame(2, 2, 1'b1);
		busy_i <= 1'b1;
		frame(1, 1, 1'b0);
		repeat (8) @(posedge clk_i);
		check({8'h00, active_o}, 9'h001);
		busy_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		check({8'h00, active_o}, 9'h000);
		for (int g = 0; g < 2; g++) begin
			guard_n_i <= g[0];
			repeat (6) @(posedge clk_i) guard_wr_i <= 1'b1;
			@(posedge clk_i) guard_wr_i <= 1'b0;
			check({7'h00, region_guard_bits_o}, g ? 9'h003 : 9'h000);
		end
		rx_ready_i <= 1'b0;
		frame(33, 32, 1'b0);
		check({8'h00, rx_overrun_o}, 9'h001);
		rx_ready_i <= 1'b1;
		repeat (40) @(posedge clk_i);
		check({8'h00, rx_valid_o}, 9'h000);
		tally_and_finish;
	end
endmodule
`default_nettype wire
